// ---- src/dtm_engine.sv ----
// DMA transfer engine: normal/cluster modes, repeat areas, interrupts
//
// Behaviour
// - Normal mode moves one item per request
// - Count register sets total; block size ignored
// - End-of-transfer output low on final item only
// - Repeat area wraps low bits, upper bits fixed
// - Separate repeat size fields for source, destination
// - Repeat size 1 to 27 bits
// - Source overflow with enable sets flag, stops
// - Escape interrupt raised only when enabled
// - Cluster mode moves whole cluster, up to 32
// - Addresses fixed, step 1/2/4, or offset
// - Misaligned items split into byte/word pieces
// - Transfer-end interrupt when count is exhausted
// - Escape end on short remainder or overflow
// - Accepted requests reported on acknowledge output
// - Module stop blocks new requests; a request under way still completes
`timescale 1ns/1ps

module dtm_engine (
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output      logic [31:0]          reg_rdata_o,
  input  wire logic                 dreq_i,
  input  wire logic [31:0]          mem_rdata_i,
  output      dtm_pkg::dtm_acc_type acc_o,
  output      logic                 request_accept_o,
  output      logic                 transfer_end_n_o,
  output      logic                 irq_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dtm_pkg::dtm_fsm_type fsm;
    logic [31:0]          src;        // source_address_reg
    logic [31:0]          dst;        // dest_address_reg
    logic [31:0]          offs;       // Offset for offset addition
    logic [31:0]          bsize;      // block_size_reg, storage only
    logic [32:0]          cnt;        // transfer_count_reg, bytes
    logic [4:0]           srs;        // src_repeat_size_field
    logic [4:0]           drs;        // dst_repeat_size_field
    logic [1:0]           smd;        // Source update mode
    logic [1:0]           dmd;        // Destination update mode
    logic                 soie;       // src_repeat_irq_enable
    logic                 doie;       // Destination overflow enable
    logic                 en;         // transfer_enable_bit
    logic                 escape_irq_enable;       // escape_irq_enable
    logic                 clus;       // Cluster mode select
    logic                 stop;       // Module stop
    logic [1:0]           asz;        // Access size code
    logic [5:0]           csz;        // Cluster size, bytes
    logic [1:0]           sts;        // Sticky events
    logic [1:0]           msk;        // Event mask
    logic [5:0]           items;      // Items left in this request
    logic [2:0]           off;        // Byte offset within item
    logic [2:0]           piece;      // Bytes in current piece
    logic                 dreq_m;     // Request synchroniser, stage 1
    logic                 dreq_s;     // Request synchroniser, stage 2
    dtm_pkg::dtm_acc_type acc;        // Bus access out
    logic                 transfer_end_out_n;     // transfer_end_out
    logic                 accept;     // request_accept_out
    logic                 irq;
    logic [31:0]          rdata;
  } dtm_state_type;

  dtm_state_type st_reg;   // Registered state
  dtm_state_type st_next;  // Next state

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Address step after one item
  function automatic logic [31:0] dtm_step(input logic [31:0] a,
                                           input logic [1:0]  md,
                                           input logic [2:0]  ib,
                                           input logic [31:0] ofs);
    case (md)
      dtm_pkg::MD_FIX: dtm_step = a;
      dtm_pkg::MD_INC: dtm_step = a + 32'(ib);
      dtm_pkg::MD_DEC: dtm_step = a - 32'(ib);
      default:         dtm_step = a + ofs;
    endcase
  endfunction : dtm_step
  // Repeat-area wrap: result {overflow, new address}
  function automatic logic [32:0] dtm_wrap(input logic [31:0] old,
                                           input logic [31:0] upd,
                                           input logic [4:0]  rs);
    logic [4:0]  n;
    logic [31:0] m;
    n = (rs > dtm_pkg::RS_MAX) ? dtm_pkg::RS_MAX : rs;
    m = ~(32'hFFFFFFFF << n);
    if (n == dtm_pkg::RS_OFF) begin
      dtm_wrap = {1'b0, upd};
    end else begin
      // Upper bits held, lower bits cycle in the area
      dtm_wrap = {|((old ^ upd) & ~m), (old & ~m) | (upd & m)};
    end
  endfunction : dtm_wrap
  // Size code of a piece
  function automatic logic [1:0] dtm_code(input logic [2:0] p);
    dtm_code = p[2] ? dtm_pkg::SZ_LONG :
               (p[1] ? dtm_pkg::SZ_WORD : dtm_pkg::SZ_BYTE);
  endfunction : dtm_code

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic [2:0]  ib;      // Bytes per item
  logic [5:0]  reqb;    // Bytes per request
  logic [5:0]  nitem;   // Items per request
  logic [31:0] sa;      // Current source access address
  logic [31:0] da;      // Current destination access address
  logic [1:0]  al;      // Combined misalignment
  logic [2:0]  rem;     // Bytes left in item
  logic [2:0]  noff;    // Offset after this piece
  logic [32:0] sw;      // Source wrap result
  logic [32:0] dw;      // Destination wrap result
  logic [32:0] ncnt;    // Count after this item
  logic [1:0]  ev;      // Events raised this cycle
  logic [1:0]  clr;     // Software clears this cycle

  always_comb begin
    st_next = st_reg;
    ev      = 2'h0;
    clr     = 2'h0;
    ib      = 3'h1 << st_reg.asz;
    sa      = st_reg.src + 32'(st_reg.off);
    da      = st_reg.dst + 32'(st_reg.off);
    al      = sa[1:0] | da[1:0];
    rem     = ib - st_reg.off;
    noff    = st_reg.off + st_reg.piece;
    sw      = dtm_wrap(st_reg.src,
                       dtm_step(st_reg.src, st_reg.smd, ib, st_reg.offs),
                       st_reg.srs);
    dw      = dtm_wrap(st_reg.dst,
                       dtm_step(st_reg.dst, st_reg.dmd, ib, st_reg.offs),
                       st_reg.drs);
    ncnt    = st_reg.cnt - 33'(ib);
    // Cluster: whole cluster per request, else one item
    if (st_reg.clus) begin
      reqb  = st_reg.csz;
      nitem = st_reg.csz >> st_reg.asz;
    end else begin
      reqb  = 6'(ib);
      nitem = 6'h01;
    end
    if (nitem == 6'h00) begin
      nitem = 6'h01;
    end
    // Pulses and synchroniser
    st_next.accept    = 1'b0;
    st_next.acc.valid = 1'b0;
    st_next.rdata     = 32'h00000000;
    st_next.dreq_m    = dreq_i;
    st_next.dreq_s    = st_reg.dreq_m;
    // Register read, data stands one cycle later
    if (reg_rd_i) begin
      case (reg_addr_i)
        dtm_pkg::OFS_SRC:    st_next.rdata = st_reg.src;
        dtm_pkg::OFS_DST:    st_next.rdata = st_reg.dst;
        dtm_pkg::OFS_CNT:    st_next.rdata = st_reg.cnt[31:0];
        dtm_pkg::OFS_BSZ:    st_next.rdata = st_reg.bsize;
        dtm_pkg::OFS_OFFSET: st_next.rdata = st_reg.offs;
        dtm_pkg::OFS_STS:    st_next.rdata = 32'(st_reg.sts);
        dtm_pkg::OFS_MSK:    st_next.rdata = 32'(st_reg.msk);
        dtm_pkg::OFS_ACR: begin
          st_next.rdata[dtm_pkg::ACR_SRS_LO +: dtm_pkg::RS_W] = st_reg.srs;
          st_next.rdata[dtm_pkg::ACR_DRS_LO +: dtm_pkg::RS_W] = st_reg.drs;
          st_next.rdata[dtm_pkg::ACR_SMD_LO +: dtm_pkg::MD_W] = st_reg.smd;
          st_next.rdata[dtm_pkg::ACR_DMD_LO +: dtm_pkg::MD_W] = st_reg.dmd;
          st_next.rdata[dtm_pkg::ACR_SOIE] = st_reg.soie;
          st_next.rdata[dtm_pkg::ACR_DOIE] = st_reg.doie;
        end
        dtm_pkg::OFS_MDR: begin
          st_next.rdata[dtm_pkg::MDR_EN]   = st_reg.en;
          st_next.rdata[dtm_pkg::MDR_ESCAPE_IRQ_ENABLE] = st_reg.escape_irq_enable;
          st_next.rdata[dtm_pkg::MDR_CLUS] = st_reg.clus;
          st_next.rdata[dtm_pkg::MDR_SZ_LO +: dtm_pkg::SZ_W]   = st_reg.asz;
          st_next.rdata[dtm_pkg::MDR_CSZ_LO +: dtm_pkg::CSZ_W] = st_reg.csz;
          st_next.rdata[dtm_pkg::MDR_STOP] = st_reg.stop;
          st_next.rdata[dtm_pkg::MDR_ESCAPE_IRQ_FLAG] = st_reg.sts[dtm_pkg::STS_ESC];
          st_next.rdata[dtm_pkg::MDR_BUSY] = st_reg.fsm != dtm_pkg::ST_IDLE;
        end
        default:             st_next.rdata = 32'h00000000;
      endcase
    end

    // Register write; engine updates below take over
    if (reg_wr_i) begin
      case (reg_addr_i)
        dtm_pkg::OFS_SRC:    st_next.src   = reg_wdata_i;
        dtm_pkg::OFS_DST:    st_next.dst   = reg_wdata_i;
        // Zero stands for the full 4 Gbytes
        dtm_pkg::OFS_CNT:    st_next.cnt   = {reg_wdata_i == 32'h00000000,
                                              reg_wdata_i};
        dtm_pkg::OFS_BSZ:    st_next.bsize = reg_wdata_i;
        dtm_pkg::OFS_OFFSET: st_next.offs  = reg_wdata_i;
        dtm_pkg::OFS_STS:    clr = reg_wdata_i[1:0];
        dtm_pkg::OFS_MSK:    st_next.msk   = reg_wdata_i[1:0];
        dtm_pkg::OFS_ACR: begin
          st_next.srs  = reg_wdata_i[dtm_pkg::ACR_SRS_LO +: dtm_pkg::RS_W];
          st_next.drs  = reg_wdata_i[dtm_pkg::ACR_DRS_LO +: dtm_pkg::RS_W];
          st_next.smd  = reg_wdata_i[dtm_pkg::ACR_SMD_LO +: dtm_pkg::MD_W];
          st_next.dmd  = reg_wdata_i[dtm_pkg::ACR_DMD_LO +: dtm_pkg::MD_W];
          st_next.soie = reg_wdata_i[dtm_pkg::ACR_SOIE];
          st_next.doie = reg_wdata_i[dtm_pkg::ACR_DOIE];
        end
        dtm_pkg::OFS_MDR: begin
          st_next.en   = reg_wdata_i[dtm_pkg::MDR_EN];
          st_next.escape_irq_enable = reg_wdata_i[dtm_pkg::MDR_ESCAPE_IRQ_ENABLE];
          st_next.clus = reg_wdata_i[dtm_pkg::MDR_CLUS];
          st_next.stop = reg_wdata_i[dtm_pkg::MDR_STOP];
          st_next.asz  = reg_wdata_i[dtm_pkg::MDR_SZ_LO +: dtm_pkg::SZ_W];
          // Code 3 is not a size; fold it to longword
          if (st_next.asz > dtm_pkg::SZ_LONG) begin
            st_next.asz = dtm_pkg::SZ_LONG;
          end
          st_next.csz = reg_wdata_i[dtm_pkg::MDR_CSZ_LO +: dtm_pkg::CSZ_W];
          if (st_next.csz > dtm_pkg::CSZ_MAX) begin
            st_next.csz = dtm_pkg::CSZ_MAX;
          end
        end
        default: ;  // Unmapped writes are dropped
      endcase
    end

    // Transfer sequencer
    case (st_reg.fsm)
      dtm_pkg::ST_IDLE: begin
        // Module stop refuses requests outright
        if (st_reg.en && !st_reg.stop && st_reg.dreq_s) begin
          st_next.accept = 1'b1;
          if (st_reg.cnt < 33'(reqb)) begin
            ev[dtm_pkg::STS_ESC] = 1'b1;
            st_next.en           = 1'b0;
          end else begin
            st_next.items = nitem;
            st_next.off   = 3'h0;
            st_next.fsm   = dtm_pkg::ST_PIECE;
          end
        end
      end
      dtm_pkg::ST_PIECE: begin
        // Largest piece both addresses can take
        st_next.piece = (rem[2] && al == 2'h0) ? 3'h4 :
                        (rem > 3'h1 && !al[0]) ? 3'h2 : 3'h1;
        st_next.acc.valid = 1'b1;
        st_next.acc.write = 1'b0;
        st_next.acc.size  = dtm_code(st_next.piece);
        st_next.acc.addr  = sa;
        st_next.acc.data  = 32'h00000000;
        // Low for the final item only
        st_next.transfer_end_out_n = !(st_reg.cnt <= 33'(ib));
        st_next.fsm    = dtm_pkg::ST_RDW;
      end
      // Read data arrives in the next cycle
      dtm_pkg::ST_RDW: st_next.fsm = dtm_pkg::ST_WR;
      dtm_pkg::ST_WR: begin
        st_next.acc.valid = 1'b1;
        st_next.acc.write = 1'b1;
        st_next.acc.addr  = da;
        st_next.acc.data  = mem_rdata_i;
        st_next.fsm       = dtm_pkg::ST_ADV;
      end
      dtm_pkg::ST_ADV: begin
        if (noff < ib) begin
          st_next.off = noff;
          st_next.fsm = dtm_pkg::ST_PIECE;
        end else begin
          // Item done: step addresses and count
          st_next.src    = sw[31:0];
          st_next.dst    = dw[31:0];
          st_next.cnt    = ncnt;
          st_next.transfer_end_out_n = 1'b1;
          st_next.off    = 3'h0;
          st_next.items  = st_reg.items - 6'h01;
          st_next.fsm    = dtm_pkg::ST_IDLE;
          if (ncnt == 33'h000000000) begin
            ev[dtm_pkg::STS_END] = 1'b1;
            st_next.en           = 1'b0;
          end else if ((sw[32] && st_reg.soie) ||
                       (dw[32] && st_reg.doie)) begin
            ev[dtm_pkg::STS_ESC] = 1'b1;
            st_next.en           = 1'b0;
          end else if (st_reg.items > 6'h01) begin
            st_next.fsm = dtm_pkg::ST_PIECE;
          end
        end
      end
      default: st_next.fsm = dtm_pkg::ST_IDLE;
    endcase

    // Sticky events: a new event beats a clear
    st_next.sts = (st_reg.sts & ~clr) | ev;
    st_next.irq = (st_next.sts[dtm_pkg::STS_END] &
                   st_next.msk[dtm_pkg::STS_END]) |
                  (st_next.sts[dtm_pkg::STS_ESC] &
                   st_next.msk[dtm_pkg::STS_ESC] & st_next.escape_irq_enable);

    if (srst_i) begin
      st_next        = '0;
      st_next.transfer_end_out_n = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    st_reg <= st_next;
  end

  assign reg_rdata_o      = st_reg.rdata;
  assign acc_o            = st_reg.acc;
  assign request_accept_o = st_reg.accept;
  assign transfer_end_n_o = st_reg.transfer_end_out_n;
  assign irq_o            = st_reg.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking dtm_cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  sequence s_read;
    acc_o.valid && !acc_o.write;
  endsequence
  sequence s_write;
    acc_o.valid && acc_o.write;
  endsequence

  // Every read is followed by its write two cycles later
  rd_wr_pair_a: assert property (
    s_read |-> ##1 !acc_o.valid ##1 s_write)
    else $error("read not followed by write");
  // Acknowledge only for a synchronised request taken in idle
  accept_cause_a: assert property (
    request_accept_o |-> $past(st_reg.fsm) == dtm_pkg::ST_IDLE &&
                         $past(st_reg.dreq_s) && $past(st_reg.en))
    else $error("acknowledge without request");
  // Module stop blocks acceptance
  stop_blocks_a: assert property (
    st_reg.stop && !reg_wr_i |=> !request_accept_o)
    else $error("request accepted in module stop");
  // End output low only while the last item is moving
  transfer_end_out_last_a: assert property (
    !transfer_end_n_o |-> st_reg.cnt <= 33'(3'h1 << st_reg.asz))
    else $error("end output low before last item");
  // Source overflow with enable raises escape and drops enable
  ovf_stop_a: assert property (
    st_reg.fsm == dtm_pkg::ST_ADV && st_next.off == 3'h0 &&
    ncnt != 33'h000000000 && sw[32] && st_reg.soie
    |=> st_reg.sts[dtm_pkg::STS_ESC] && !st_reg.en &&
        st_reg.fsm == dtm_pkg::ST_IDLE)
    else $error("source overflow did not stop");
  // Escape interrupt needs its enable
  esc_gate_a: assert property (
    irq_o && !(st_reg.sts[dtm_pkg::STS_END] &&
               st_reg.msk[dtm_pkg::STS_END]) |-> st_reg.escape_irq_enable)
    else $error("escape interrupt while disabled");
  // Count exhausted sets the end flag next cycle
  end_flag_a: assert property (
    st_reg.fsm == dtm_pkg::ST_ADV && noff >= ib &&
    ncnt == 33'h000000000
    |=> st_reg.sts[dtm_pkg::STS_END] && !st_reg.en)
    else $error("end flag not raised");
  // Pieces never cross their natural boundary
  piece_align_a: assert property (
    acc_o.valid |-> (acc_o.size != dtm_pkg::SZ_LONG ||
                     acc_o.addr[1:0] == 2'h0) &&
                    (acc_o.size != dtm_pkg::SZ_WORD || !acc_o.addr[0]))
    else $error("misaligned piece issued");
  // Destination wrap keeps bits above the area
  dst_wrap_a: assert property (
    st_reg.fsm == dtm_pkg::ST_ADV && noff >= ib &&
    st_reg.drs != dtm_pkg::RS_OFF && st_reg.drs <= dtm_pkg::RS_MAX
    |-> ((st_reg.dst ^ dw[31:0]) >> st_reg.drs) == 32'h00000000)
    else $error("repeat area upper bits changed");
  // Short remainder escapes without a transfer
  short_esc_a: assert property (
    st_reg.fsm == dtm_pkg::ST_IDLE && st_reg.en && !st_reg.stop &&
    st_reg.dreq_s && st_reg.cnt < 33'(reqb) && !reg_wr_i
    |=> st_reg.sts[dtm_pkg::STS_ESC] ##1 !acc_o.valid)
    else $error("short remainder not escaped");

endmodule : dtm_engine

// ---- src/dtm_pkg.sv ----
// Package: register map, field layout, codes and types of the DMA engine
package dtm_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam int          ADDR_W     = 8;
  localparam logic [7:0]  OFS_SRC    = 8'h00;  // Source address
  localparam logic [7:0]  OFS_DST    = 8'h04;  // Destination address
  localparam logic [7:0]  OFS_CNT    = 8'h08;  // Transfer count, bytes
  localparam logic [7:0]  OFS_BSZ    = 8'h0C;  // Block size, unused here
  localparam logic [7:0]  OFS_ACR    = 8'h10;  // Address control
  localparam logic [7:0]  OFS_MDR    = 8'h14;  // Mode control
  localparam logic [7:0]  OFS_OFFSET = 8'h18;  // Address offset
  localparam logic [7:0]  OFS_STS    = 8'h1C;  // Interrupt status
  localparam logic [7:0]  OFS_MSK    = 8'h20;  // Interrupt mask

  // ---------------------------------------------------------------
  // Field positions and widths
  // ---------------------------------------------------------------
  localparam int RS_W       = 5;   // Repeat size field width
  localparam int MD_W       = 2;   // Address update mode width
  localparam int SZ_W       = 2;   // Access size code width
  localparam int CSZ_W      = 6;   // Cluster byte count width
  localparam int ACR_SRS_LO = 0;   // Source repeat size
  localparam int ACR_DRS_LO = 8;   // Destination repeat size
  localparam int ACR_SMD_LO = 16;  // Source update mode
  localparam int ACR_DMD_LO = 18;  // Destination update mode
  localparam int ACR_SOIE   = 20;  // Source overflow stop enable
  localparam int ACR_DOIE   = 21;  // Destination overflow stop enable
  localparam int MDR_EN     = 0;   // Transfer enable
  localparam int MDR_ESCAPE_IRQ_ENABLE   = 1;   // Escape interrupt enable
  localparam int MDR_CLUS   = 2;   // Cluster transfer mode
  localparam int MDR_SZ_LO  = 3;   // Access size
  localparam int MDR_CSZ_LO = 8;   // Cluster size in bytes
  localparam int MDR_STOP   = 15;  // Module stop
  localparam int MDR_ESCAPE_IRQ_FLAG   = 16;  // Escape flag, read only view
  localparam int MDR_BUSY   = 17;  // Engine busy, read only
  localparam int STS_END    = 0;   // Transfer end event
  localparam int STS_ESC    = 1;   // Escape end event

  // ---------------------------------------------------------------
  // Codes and limits
  // ---------------------------------------------------------------
  localparam logic [4:0] RS_OFF   = 5'h00;  // Repeat area disabled
  localparam logic [4:0] RS_MAX   = 5'h1B;  // 27 bits, 128 Mbytes
  localparam logic [5:0] CSZ_MAX  = 6'h20;  // 32-byte cluster
  localparam logic [1:0] SZ_BYTE  = 2'h0;
  localparam logic [1:0] SZ_WORD  = 2'h1;
  localparam logic [1:0] SZ_LONG  = 2'h2;
  localparam logic [1:0] MD_FIX   = 2'h0;
  localparam logic [1:0] MD_INC   = 2'h1;
  localparam logic [1:0] MD_DEC   = 2'h2;
  localparam logic [1:0] MD_OFS   = 2'h3;
  localparam int         CNT_W    = 33;     // Holds the full 4 Gbytes

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_PIECE = 3'h1,
    ST_RDW   = 3'h2,
    ST_WR    = 3'h3,
    ST_ADV   = 3'h4
  } dtm_fsm_type;

  typedef struct packed {
    logic        valid;  // One-cycle access strobe
    logic        write;  // 1 write, 0 read
    logic [1:0]  size;   // Byte, word or longword
    logic [31:0] addr;
    logic [31:0] data;   // Write data
  } dtm_acc_type;

endpackage : dtm_pkg

// ---- testbench/dtm_peer.sv ----
// Partner model: requesting peripheral and memory behind the engine
`timescale 1ns/1ps
module dtm_peer (
  input  wire logic                 clock_i,
  input  wire logic                 srst_i,
  input  wire logic [3:0]           num_i,
  input  wire logic                 load_i,
  input  wire logic                 request_accept_i,
  input  wire dtm_pkg::dtm_acc_type acc_i,
  output      logic                 dreq_o,
  output      logic [31:0]          mem_rdata_o
);
  logic [3:0] left_reg;  // Requests still to raise
  // Level held high until every loaded request is accepted
  always_ff @(posedge clock_i) begin
    if (srst_i) left_reg <= 4'h0;
    else if (load_i) left_reg <= num_i;
    else if (request_accept_i && left_reg != 4'h0) left_reg <= left_reg - 4'h1;
  end
  assign dreq_o = (left_reg != 4'h0);
  // Data valid only the cycle after a read; toggles so stale data shows
  always_ff @(posedge clock_i) begin
    if (srst_i) mem_rdata_o <= 32'h0;
    else if (acc_i.valid && !acc_i.write) mem_rdata_o <= acc_i.addr ^ 32'hA5;
    else mem_rdata_o <= ~mem_rdata_o;
  end
endmodule : dtm_peer

// ---- testbench/dtm_engine_tb.sv ----
// Testbench: register, transfer, overflow and stop scenarios
`timescale 1ns/1ps
module dtm_engine_tb;
  logic clock_i = 0, srst_i = 1, reg_wr_i = 0, reg_rd_i = 0, ld = 0, dreq_i;
  logic [7:0] reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o, mem_rdata_i, v;
  logic [3:0] num = 0;
  logic request_accept_o, transfer_end_n_o, irq_o;
  dtm_pkg::dtm_acc_type acc_o;
  int fail_count = 0, n_compared = 0, n_acc = 0, t;
  logic [31:0] wa[$], wd[$];
  logic wt[$];
  logic [1:0] ws[$];
  dtm_engine dut (.clock_i(clock_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .dreq_i(dreq_i), .mem_rdata_i(mem_rdata_i),
    .acc_o(acc_o), .request_accept_o(request_accept_o),
    .transfer_end_n_o(transfer_end_n_o), .irq_o(irq_o));
  dtm_peer peer (.clock_i(clock_i), .srst_i(srst_i), .num_i(num), .load_i(ld),
    .request_accept_i(request_accept_o), .acc_i(acc_o), .dreq_o(dreq_i),
    .mem_rdata_o(mem_rdata_i));
  initial forever #50 clock_i = ~clock_i;
  // Collect every write access with the end-of-transfer level beside it
  always @(posedge clock_i) if (!srst_i) begin
    if (acc_o.valid === 1'b1 && acc_o.write === 1'b1) begin
      wa.push_back(acc_o.addr); wd.push_back(acc_o.data);
      wt.push_back(transfer_end_n_o); ws.push_back(acc_o.size);
    end
    if (request_accept_o === 1'b1) n_acc++;
  end
  task automatic final_report;
    if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i); reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge clock_i); reg_wr_i <= 0; #1;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clock_i); reg_rd_i <= 1; reg_addr_i <= a;
    @(posedge clock_i); reg_rd_i <= 0;
    #1 v = reg_rdata_o;
  endtask : rd
  // Wait, bounded, until n_acc reaches t, then let the transfer finish
  task automatic wait_acc;
    for (int i = 0; i < 300 && n_acc < t; i++) @(posedge clock_i);
    if (n_acc < t) begin fail_count++; final_report; end
    repeat (20) @(posedge clock_i);
  endtask : wait_acc
  task automatic go(input logic [3:0] n);
    t = n_acc + n;
    @(posedge clock_i); ld <= 1; num <= n;
    @(posedge clock_i); ld <= 0;
    wait_acc;
  endtask : go
  task automatic t_reset;
    rd(dtm_pkg::OFS_MDR); chk("mdr", 0, v);
    rd(8'h24); chk("unmapped", 0, v);
  endtask : t_reset
  task automatic t_normal;
    wr(dtm_pkg::OFS_SRC, 32'h40); wr(dtm_pkg::OFS_DST, 32'h80);
    wr(dtm_pkg::OFS_CNT, 32'h2); wr(dtm_pkg::OFS_BSZ, 32'h1);
    wr(dtm_pkg::OFS_ACR, 32'h0005_0000); wr(dtm_pkg::OFS_MSK, 32'h1);
    wr(dtm_pkg::OFS_MDR, 32'h1); go(2);
    chk("writes", 2, wa.size());
    chk("addr1", 32'h81, wa[1]);
    chk("data1", 32'hE4, {24'h0, wd[1][7:0]});
    chk("tend0", 1, {31'h0, wt[0]});
    chk("tend1", 0, {31'h0, wt[1]});
    rd(dtm_pkg::OFS_CNT); chk("cnt", 0, v);
    chk("irq_end", 1, {31'h0, irq_o});
    wr(dtm_pkg::OFS_STS, 32'h1); chk("irq_clr", 0, {31'h0, irq_o});
  endtask : t_normal
  task automatic t_ovf;
    wr(dtm_pkg::OFS_SRC, 32'h101); wr(dtm_pkg::OFS_DST, 32'h200);
    wr(dtm_pkg::OFS_CNT, 32'h4); wr(dtm_pkg::OFS_ACR, 32'h0015_0101);
    wr(dtm_pkg::OFS_MSK, 32'h2); wr(dtm_pkg::OFS_MDR, 32'h3); go(1);
    rd(dtm_pkg::OFS_SRC); chk("wrap", 32'h100, v);
    rd(dtm_pkg::OFS_MDR); chk("stop", 32'h0001_0002, v);
    chk("irq_esc", 1, {31'h0, irq_o});
    wr(dtm_pkg::OFS_MDR, 32'h3); go(1);
    chk("resume", 32'h201, wa[wa.size()-1]);
    rd(dtm_pkg::OFS_DST); chk("dst_wrap", 32'h200, v);
    rd(dtm_pkg::OFS_MDR); chk("dst_nostop", 32'h0001_0003, v);
    wr(dtm_pkg::OFS_STS, 32'h2);
  endtask : t_ovf
  task automatic t_stop;
    wr(dtm_pkg::OFS_CNT, 32'h2); wr(dtm_pkg::OFS_DST, 32'h201);
    wr(dtm_pkg::OFS_ACR, 32'h0025_0100); wr(dtm_pkg::OFS_MDR, 32'h0000_8001);
    t = n_acc; @(posedge clock_i); ld <= 1; num <= 1;
    @(posedge clock_i); ld <= 0; repeat (20) @(posedge clock_i);
    chk("stopped", t, n_acc);
    t = t + 1; wr(dtm_pkg::OFS_MDR, 32'h1); wait_acc;
    rd(dtm_pkg::OFS_MDR); chk("dst_stop", 32'h0001_0000, v);
  endtask : t_stop
  // Cluster of two misaligned longwords, then a short remainder
  task automatic t_clus;
    int n;
    wr(dtm_pkg::OFS_STS, 32'h3); wr(dtm_pkg::OFS_SRC, 32'h302);
    wr(dtm_pkg::OFS_DST, 32'h402); wr(dtm_pkg::OFS_CNT, 32'h8);
    wr(dtm_pkg::OFS_ACR, 32'h0005_0000); wr(dtm_pkg::OFS_MSK, 32'h2);
    wr(dtm_pkg::OFS_MDR, 32'h815);
    n = wa.size(); go(1);
    chk("clus_n", n + 4, wa.size());
    chk("clus_addr", 32'h408, wa[n+3]);
    chk("clus_size", dtm_pkg::SZ_WORD, ws[n+3]);
    chk("clus_data", 32'h3AD, wd[n+3]);
    chk("transfer_end_out_c1", 1, wt[n+1]);
    chk("transfer_end_out_c2", 0, wt[n+2]);
    wr(dtm_pkg::OFS_CNT, 32'h4); wr(dtm_pkg::OFS_MDR, 32'h815); go(1);
    chk("short_n", n + 4, wa.size());
    rd(dtm_pkg::OFS_MDR); chk("short_esc", 32'h0001_0814, v);
    chk("esc_masked", 0, irq_o);
    wr(dtm_pkg::OFS_MDR, 32'h816); chk("esc_irq", 1, irq_o);
    wr(dtm_pkg::OFS_STS, 32'h3);
  endtask : t_clus
  initial begin
    repeat (4) @(posedge clock_i);
    srst_i <= 0;
    t_reset; t_normal; t_ovf; t_stop; t_clus;
    final_report;
  end
endmodule : dtm_engine_tb
